/* File: afe_regs.sv */
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps

module afe_regs
  import afe_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire afe_pkg::afe_bus_s bus,
  output logic [7:0] rdata,
  // Analog outputs seen from the macros (asynchronous)
  input wire logic [1:0] opamp_out,
  input wire logic [1:0] cmp_out,
  // Control to the analog macros
  output afe_pkg::afe_ctl_s ctl
);
  import afe_pkg::*;

  typedef struct packed {
    logic [7:0] sw_lo;
    logic [7:0] sw_hi;
    logic [2:0] dac_en;
    logic [7:0] dac0;
    logic [7:0] dac1;
    logic [7:0] dac2;
    logic [7:0] gain;
    logic [7:0] opa0_ctl;
    logic [7:0] opa1_ctl;
    logic [7:0] opa0_trim;
    logic [7:0] opa1_trim;
    logic [7:0] cmp0_ctl;
    logic [7:0] cmp1_ctl;
    logic [7:0] cmp0_trim;
    logic [7:0] cmp1_trim;
    logic [7:0] hyst;
    logic [1:0] opa_s1;
    logic [1:0] opa_s2;
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;
    logic [6:0] cnt0;
    logic [6:0] cnt1;
    logic [1:0] filt;
    logic [7:0] rdata;
  } afe_state_s;

  afe_state_s state_ff;
  afe_state_s nxt_state;
  logic [1:0] raw;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [6:0] deb_len(input logic [1:0] sel);
    case (sel)
      2'b01: deb_len = DEB_LEN_01;
      2'b10: deb_len = DEB_LEN_10;
      2'b11: deb_len = DEB_LEN_11;
      default: deb_len = 7'h00;
    endcase
  endfunction

  function automatic logic [5:0] gain_ratio(input logic [2:0] code);
    case (code)
      3'b000: gain_ratio = 6'h01;
      3'b001: gain_ratio = 6'h02;
      3'b010: gain_ratio = 6'h04;
      3'b011: gain_ratio = 6'h08;
      3'b100: gain_ratio = 6'h10;
      3'b101: gain_ratio = 6'h20;
      3'b110: gain_ratio = 6'h38;
      default: gain_ratio = 6'h01;
    endcase
  endfunction

  // Filter counts consecutive samples that differ from the filtered bit; it moves only
  // once the run exceeds the selected length by one, so glitches are swallowed.
  function automatic logic [7:0] filt_step(input logic [6:0] cnt, input logic cur,
                                           input logic sample, input logic [1:0] sel);
    logic [6:0] len;
    len = deb_len(sel);
    if (sample == cur) begin
      filt_step = {cur, 7'h00};
    end else if (cnt >= len) begin
      filt_step = {sample, 7'h00};
    end else begin
      filt_step = {cur, 7'(cnt + 7'h01)};
    end
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [7:0] step0;
    logic [7:0] step1;
    step0 = 8'h00;
    step1 = 8'h00;
    nxt_state = state_ff;
    // Two-flop synchronisers on the analog outputs
    nxt_state.opa_s1 = opamp_out;
    nxt_state.opa_s2 = state_ff.opa_s1;
    nxt_state.cmp_s1 = cmp_out;
    nxt_state.cmp_s2 = state_ff.cmp_s1;
    // Writes land on the next edge, masked to implemented bits
    if (bus.wr) begin
      if (bus.addr == ADDR_SW_LOW) begin
        nxt_state.sw_lo = bus.wdata;
      end else if (bus.addr == ADDR_SW_HIGH) begin
        nxt_state.sw_hi = bus.wdata & MASK_SW_HIGH;
      end else if (bus.addr == ADDR_DAC0_EN) begin
        nxt_state.dac_en[0] = bus.wdata[DAC_EN_BIT];
      end else if (bus.addr == ADDR_DAC1_EN) begin
        nxt_state.dac_en[1] = bus.wdata[DAC_EN_BIT];
      end else if (bus.addr == ADDR_DAC2_EN) begin
        nxt_state.dac_en[2] = bus.wdata[DAC_EN_BIT];
      end else if (bus.addr == ADDR_DAC0_LVL) begin
        nxt_state.dac0 = bus.wdata;
      end else if (bus.addr == ADDR_DAC1_LVL) begin
        nxt_state.dac1 = bus.wdata;
      end else if (bus.addr == ADDR_DAC2_LVL) begin
        nxt_state.dac2 = bus.wdata;
      end else if (bus.addr == ADDR_GAIN) begin
        nxt_state.gain = bus.wdata & MASK_GAIN;
      end else if (bus.addr == ADDR_OPA0_CTL) begin
        nxt_state.opa0_ctl = bus.wdata & MASK_OPA_CTL;
      end else if (bus.addr == ADDR_OPA1_CTL) begin
        nxt_state.opa1_ctl = bus.wdata & MASK_OPA_CTL;
      end else if (bus.addr == ADDR_OPA0_TRIM) begin
        nxt_state.opa0_trim = bus.wdata;
      end else if (bus.addr == ADDR_OPA1_TRIM) begin
        nxt_state.opa1_trim = bus.wdata;
      end else if (bus.addr == ADDR_CMP0_CTL) begin
        nxt_state.cmp0_ctl = bus.wdata & MASK_CMP_CTL;
      end else if (bus.addr == ADDR_CMP1_CTL) begin
        nxt_state.cmp1_ctl = bus.wdata & MASK_CMP_CTL;
      end else if (bus.addr == ADDR_CMP0_TRIM) begin
        nxt_state.cmp0_trim = bus.wdata & MASK_CMP_TRIM;
      end else if (bus.addr == ADDR_CMP1_TRIM) begin
        nxt_state.cmp1_trim = bus.wdata & MASK_CMP_TRIM;
      end else if (bus.addr == ADDR_CMP_HYST) begin
        nxt_state.hyst = bus.wdata & MASK_CMP_HYST;
      end
    end
    // Debounce on the polarity-adjusted raw status
    step0 = filt_step(state_ff.cnt0, state_ff.filt[0], raw[0], state_ff.cmp0_ctl[3:2]);
    step1 = filt_step(state_ff.cnt1, state_ff.filt[1], raw[1], state_ff.cmp1_ctl[3:2]);
    nxt_state.filt = {step1[7], step0[7]};
    nxt_state.cnt0 = step0[6:0];
    nxt_state.cnt1 = step1[6:0];
    // Read data stands only in the cycle after the strobe
    nxt_state.rdata = 8'h00;
    if (bus.rd) begin
      if (bus.addr == ADDR_SW_LOW) begin
        nxt_state.rdata = state_ff.sw_lo;
      end else if (bus.addr == ADDR_SW_HIGH) begin
        nxt_state.rdata = state_ff.sw_hi;
      end else if (bus.addr == ADDR_DAC0_EN) begin
        nxt_state.rdata = {state_ff.dac_en[0], 7'h00};
      end else if (bus.addr == ADDR_DAC1_EN) begin
        nxt_state.rdata = {state_ff.dac_en[1], 7'h00};
      end else if (bus.addr == ADDR_DAC2_EN) begin
        nxt_state.rdata = {state_ff.dac_en[2], 7'h00};
      end else if (bus.addr == ADDR_DAC0_LVL) begin
        nxt_state.rdata = state_ff.dac0;
      end else if (bus.addr == ADDR_DAC1_LVL) begin
        nxt_state.rdata = state_ff.dac1;
      end else if (bus.addr == ADDR_DAC2_LVL) begin
        nxt_state.rdata = state_ff.dac2;
      end else if (bus.addr == ADDR_GAIN) begin
        nxt_state.rdata = state_ff.gain;
      end else if (bus.addr == ADDR_OPA0_CTL) begin
        nxt_state.rdata = state_ff.opa0_ctl;
        nxt_state.rdata[OPA_STAT_BIT] = state_ff.opa0_trim[OPA_CALM_BIT]
                                        & state_ff.opa_s2[0];
      end else if (bus.addr == ADDR_OPA1_CTL) begin
        nxt_state.rdata = state_ff.opa1_ctl;
        nxt_state.rdata[OPA_STAT_BIT] = state_ff.opa1_trim[OPA_CALM_BIT]
                                        & state_ff.opa_s2[1];
      end else if (bus.addr == ADDR_OPA0_TRIM) begin
        nxt_state.rdata = state_ff.opa0_trim;
      end else if (bus.addr == ADDR_OPA1_TRIM) begin
        nxt_state.rdata = state_ff.opa1_trim;
      end else if (bus.addr == ADDR_CMP0_CTL) begin
        nxt_state.rdata = state_ff.cmp0_ctl;
        nxt_state.rdata[CMP_RAW_BIT] = raw[0];
        nxt_state.rdata[CMP_FILT_BIT] = state_ff.filt[0];
      end else if (bus.addr == ADDR_CMP1_CTL) begin
        nxt_state.rdata = state_ff.cmp1_ctl;
        nxt_state.rdata[CMP_RAW_BIT] = raw[1];
        nxt_state.rdata[CMP_FILT_BIT] = state_ff.filt[1];
      end else if (bus.addr == ADDR_CMP0_TRIM) begin
        nxt_state.rdata = state_ff.cmp0_trim;
      end else if (bus.addr == ADDR_CMP1_TRIM) begin
        nxt_state.rdata = state_ff.cmp1_trim;
      end else if (bus.addr == ADDR_CMP_HYST) begin
        nxt_state.rdata = state_ff.hyst;
      end
    end
  end

  // Disabled comparator output is low, then polarity applies
  assign raw[0] = (state_ff.cmp_s2[0] & state_ff.cmp0_ctl[CMP_EN_BIT])
                  ^ state_ff.gain[CMP0_INV_BIT];
  assign raw[1] = (state_ff.cmp_s2[1] & state_ff.cmp1_ctl[CMP_EN_BIT])
                  ^ state_ff.gain[CMP1_INV_BIT];

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= '0;
      state_ff.opa0_trim <= RST_OPA_TRIM;
      state_ff.opa1_trim <= RST_OPA_TRIM;
      state_ff.cmp0_trim <= RST_CMP_TRIM;
      state_ff.cmp1_trim <= RST_CMP_TRIM;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // Outputs to the analog macros
  // ****************************************************************
  assign rdata = state_ff.rdata;
  always_comb begin
    // Top two switch positions are the input selects, carried on their own
    ctl.sw_closed = {2'b00, state_ff.sw_hi[2:0], state_ff.sw_lo};
    ctl.cmp0_neg_input_sel = state_ff.sw_hi[CMP0_NEG_SEL_BIT];
    ctl.cmp1_neg_input_sel = state_ff.sw_hi[CMP1_NEG_SEL_BIT];
    ctl.ref_dac_on = state_ff.dac_en;
    ctl.dac0_code = state_ff.dac0;
    ctl.dac1_code = state_ff.dac1;
    ctl.dac2_code = state_ff.dac2;
    ctl.amp_gain_code = state_ff.gain[2:0];
    ctl.amp_gain_ratio = gain_ratio(state_ff.gain[2:0]);
    ctl.opamp_on = {state_ff.opa1_ctl[OPA_EN_BIT], state_ff.opa0_ctl[OPA_EN_BIT]};
    ctl.opamp0_bandwidth_sel = state_ff.opa0_ctl[1:0];
    ctl.opamp1_bandwidth_sel = state_ff.opa1_ctl[1:0];
    ctl.opamp_cal_mode = {state_ff.opa1_trim[OPA_CALM_BIT],
                          state_ff.opa0_trim[OPA_CALM_BIT]};
    ctl.opamp_cal_ref_sel = {state_ff.opa1_trim[OPA_REF_BIT],
                             state_ff.opa0_trim[OPA_REF_BIT]};
    ctl.opamp0_trim_code = state_ff.opa0_trim[5:0];
    ctl.opamp1_trim_code = state_ff.opa1_trim[5:0];
    ctl.cmp_on = {state_ff.cmp1_ctl[CMP_EN_BIT], state_ff.cmp0_ctl[CMP_EN_BIT]};
    ctl.cmp0_current = state_ff.cmp0_ctl[1:0];
    ctl.cmp1_current = state_ff.cmp1_ctl[1:0];
    ctl.cmp0_trim = state_ff.cmp0_trim[6:0];
    ctl.cmp1_trim = state_ff.cmp1_trim[6:0];
    ctl.cmp_hyst = state_ff.hyst[3:0];
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_opa_stat_low;
    @(posedge clk) disable iff (!reset_n)
      (bus.rd && bus.addr == ADDR_OPA0_CTL && !state_ff.opa0_trim[OPA_CALM_BIT])
      |=> !rdata[OPA_STAT_BIT];
  endproperty
  a_opa_stat_low: assert property (p_opa_stat_low) else $error("opamp status not low");

  property p_unimpl_zero;
    @(posedge clk) disable iff (!reset_n)
      (bus.rd && bus.addr == ADDR_SW_HIGH) |=> (rdata[7:5] == 3'b000);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("reserved bits nonzero");

  property p_write_next;
    @(posedge clk) disable iff (!reset_n)
      (bus.wr && bus.addr == ADDR_DAC1_LVL) |=> (ctl.dac1_code == $past(bus.wdata));
  endproperty
  a_write_next: assert property (p_write_next) else $error("write not applied");

  property p_dac_en;
    @(posedge clk) disable iff (!reset_n)
      (bus.wr && bus.addr == ADDR_DAC2_EN) |=> (ctl.ref_dac_on[2] == $past(bus.wdata[7]));
  endproperty
  a_dac_en: assert property (p_dac_en) else $error("dac enable wrong");

  property p_gain_56;
    @(posedge clk) disable iff (!reset_n)
      (ctl.amp_gain_code == 3'b110) |-> (ctl.amp_gain_ratio == 6'h38);
  endproperty
  a_gain_56: assert property (p_gain_56) else $error("gain 56 wrong");

  property p_cmp_off;
    @(posedge clk) disable iff (!reset_n)
      !state_ff.cmp0_ctl[CMP_EN_BIT] |-> (raw[0] == state_ff.gain[CMP0_INV_BIT]);
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("disabled cmp not low");

  property p_nodeb;
    @(posedge clk) disable iff (!reset_n)
      (state_ff.cmp0_ctl[3:2] == 2'b00 && raw[0] != state_ff.filt[0]
       && $stable(state_ff.cmp0_ctl)) |=> (state_ff.filt[0] == $past(raw[0]));
  endproperty
  a_nodeb: assert property (p_nodeb) else $error("no-debounce lag");

  property p_deb_hold;
    @(posedge clk) disable iff (!reset_n)
      (state_ff.cmp0_ctl[3:2] == 2'b01 && $changed(state_ff.filt[0]))
      |-> $past(raw[0] == state_ff.filt[0], 1) == 1'b0 && $past(state_ff.cnt0) >= 7'h20;
  endproperty
  a_deb_hold: assert property (p_deb_hold) else $error("filter moved early");

  property p_sw_hi_map;
    @(posedge clk) disable iff (!reset_n)
      (bus.wr && bus.addr == ADDR_SW_HIGH)
      |=> (ctl.sw_closed[12:8] == {2'b00, $past(bus.wdata[2:0])});
  endproperty
  a_sw_hi_map: assert property (p_sw_hi_map) else $error("high switches wrong");

  property p_cmp1_sel;
    @(posedge clk) disable iff (!reset_n)
      (bus.wr && bus.addr == ADDR_SW_HIGH)
      |=> (ctl.cmp1_neg_input_sel == $past(bus.wdata[CMP1_NEG_SEL_BIT]));
  endproperty
  a_cmp1_sel: assert property (p_cmp1_sel) else $error("cmp1 input select wrong");

  property p_cmp0_sel;
    @(posedge clk) disable iff (!reset_n)
      (bus.wr && bus.addr == ADDR_SW_HIGH)
      |=> (ctl.cmp0_neg_input_sel == $past(bus.wdata[CMP0_NEG_SEL_BIT]));
  endproperty
  a_cmp0_sel: assert property (p_cmp0_sel) else $error("cmp0 input select wrong");

  property p_opa_on;
    @(posedge clk) disable iff (!reset_n)
      (bus.wr && bus.addr == ADDR_OPA1_CTL)
      |=> (ctl.opamp_on[1] == $past(bus.wdata[OPA_EN_BIT]));
  endproperty
  a_opa_on: assert property (p_opa_on) else $error("opamp enable wrong");

  property p_opa_bw;
    @(posedge clk) disable iff (!reset_n)
      (bus.wr && bus.addr == ADDR_OPA1_CTL)
      |=> (ctl.opamp1_bandwidth_sel == $past(bus.wdata[1:0]));
  endproperty
  a_opa_bw: assert property (p_opa_bw) else $error("opamp bandwidth wrong");

  property p_cal_mode;
    @(posedge clk) disable iff (!reset_n)
      (bus.wr && bus.addr == ADDR_OPA1_TRIM)
      |=> (ctl.opamp_cal_mode[1] == $past(bus.wdata[OPA_CALM_BIT]));
  endproperty
  a_cal_mode: assert property (p_cal_mode) else $error("calibration mode wrong");

  property p_cal_ref;
    @(posedge clk) disable iff (!reset_n)
      (bus.wr && bus.addr == ADDR_OPA0_TRIM)
      |=> (ctl.opamp_cal_ref_sel[0] == $past(bus.wdata[OPA_REF_BIT]));
  endproperty
  a_cal_ref: assert property (p_cal_ref) else $error("calibration reference wrong");

  property p_trim_code;
    @(posedge clk) disable iff (!reset_n)
      (bus.wr && bus.addr == ADDR_OPA1_TRIM)
      |=> (ctl.opamp1_trim_code == $past(bus.wdata[5:0]));
  endproperty
  a_trim_code: assert property (p_trim_code) else $error("trim code wrong");
endmodule

/* File: afe_pkg.sv */
package afe_pkg;

  // ****************************************************************
  // Register indices (byte addresses on the plain 8-bit port)
  // ****************************************************************
  localparam logic [4:0] ADDR_SW_LOW = 5'h00;
  localparam logic [4:0] ADDR_SW_HIGH = 5'h01;
  localparam logic [4:0] ADDR_DAC0_EN = 5'h02;
  localparam logic [4:0] ADDR_DAC1_EN = 5'h03;
  localparam logic [4:0] ADDR_DAC2_EN = 5'h04;
  localparam logic [4:0] ADDR_DAC0_LVL = 5'h05;
  localparam logic [4:0] ADDR_DAC1_LVL = 5'h06;
  localparam logic [4:0] ADDR_DAC2_LVL = 5'h07;
  localparam logic [4:0] ADDR_GAIN = 5'h08;
  localparam logic [4:0] ADDR_OPA0_CTL = 5'h09;
  localparam logic [4:0] ADDR_OPA1_CTL = 5'h0A;
  localparam logic [4:0] ADDR_OPA0_TRIM = 5'h0B;
  localparam logic [4:0] ADDR_OPA1_TRIM = 5'h0C;
  localparam logic [4:0] ADDR_CMP0_CTL = 5'h0D;
  localparam logic [4:0] ADDR_CMP1_CTL = 5'h0E;
  localparam logic [4:0] ADDR_CMP0_TRIM = 5'h0F;
  localparam logic [4:0] ADDR_CMP1_TRIM = 5'h10;
  localparam logic [4:0] ADDR_CMP_HYST = 5'h11;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DAC_EN_BIT = 7;
  localparam int CMP0_INV_BIT = 7;
  localparam int CMP1_INV_BIT = 6;
  localparam int OPA_EN_BIT = 6;
  localparam int OPA_STAT_BIT = 5;
  localparam int OPA_CALM_BIT = 7;
  localparam int OPA_REF_BIT = 6;
  localparam int CMP_RAW_BIT = 7;
  localparam int CMP_EN_BIT = 6;
  localparam int CMP_FILT_BIT = 5;
  localparam int CMP0_NEG_SEL_BIT = 3;
  localparam int CMP1_NEG_SEL_BIT = 4;

  // Writable-bit masks; unimplemented bits drop writes and read zero
  localparam logic [7:0] MASK_SW_HIGH = 8'h1F;
  localparam logic [7:0] MASK_DAC_EN = 8'h80;
  localparam logic [7:0] MASK_GAIN = 8'hC7;
  localparam logic [7:0] MASK_OPA_CTL = 8'h43;
  localparam logic [7:0] MASK_CMP_CTL = 8'h4F;
  localparam logic [7:0] MASK_CMP_TRIM = 8'h7F;
  localparam logic [7:0] MASK_CMP_HYST = 8'h0F;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_OPA_TRIM = 8'h20;
  localparam logic [7:0] RST_CMP_TRIM = 8'h10;

  // ****************************************************************
  // Debounce lengths in system clocks (upper figure of each range)
  // ****************************************************************
  localparam logic [6:0] DEB_LEN_01 = 7'h20;
  localparam logic [6:0] DEB_LEN_10 = 7'h40;
  localparam logic [6:0] DEB_LEN_11 = 7'h7F;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } afe_bus_s;

  typedef struct packed {
    logic [12:0] sw_closed;
    logic cmp0_neg_input_sel;
    logic cmp1_neg_input_sel;
    logic [2:0] ref_dac_on;
    logic [7:0] dac0_code;
    logic [7:0] dac1_code;
    logic [7:0] dac2_code;
    logic [2:0] amp_gain_code;
    logic [5:0] amp_gain_ratio;
    logic [1:0] opamp_on;
    logic [1:0] opamp0_bandwidth_sel;
    logic [1:0] opamp1_bandwidth_sel;
    logic [1:0] opamp_cal_mode;
    logic [1:0] opamp_cal_ref_sel;
    logic [5:0] opamp0_trim_code;
    logic [5:0] opamp1_trim_code;
    logic [1:0] cmp_on;
    logic [1:0] cmp0_current;
    logic [1:0] cmp1_current;
    logic [6:0] cmp0_trim;
    logic [6:0] cmp1_trim;
    logic [3:0] cmp_hyst;
  } afe_ctl_s;

endpackage

/* File: afe_regs_tb_top.sv */
`timescale 1ns/10ps

module afe_regs_tb_top;
  import afe_pkg::*;

  // ****************************************************************
  // Stimulus, design and bookkeeping
  // ****************************************************************
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  afe_bus_s bus = '0;
  logic [7:0] rdata;
  logic [1:0] opamp_out = 2'b00;
  logic [1:0] cmp_out = 2'b00;
  afe_ctl_s ctl;
  int n_fail = 0;
  int n_checks = 0;
  logic [7:0] rv;

  // Expected read-back after reset, and after writing all ones
  localparam logic [7:0] RST_TAB [18] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h20, 8'h00, 8'h00, 8'h10, 8'h10, 8'h00};
  localparam logic [7:0] ONES_TAB [18] = '{8'hFF, 8'h1F, 8'h80, 8'h80, 8'h80, 8'hFF,
    8'hFF, 8'hFF, 8'hC7, 8'h43, 8'h43, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h7F, 8'h7F, 8'h0F};
  localparam logic [7:0] RATIO_TAB [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
    8'h38, 8'h01};
  // Sample points must straddle the documented filter window plus two sync stages
  localparam int DEB_LO [4] = '{0, 25, 55, 118};
  localparam int DEB_HI [4] = '{4, 40, 75, 140};

  always #10 clk = ~clk;

  afe_regs dut_u (
    .clk(clk),
    .reset_n(reset_n),
    .bus(bus),
    .rdata(rdata),
    .opamp_out(opamp_out),
    .cmp_out(cmp_out),
    .ctl(ctl)
  );

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check_reset_vals();
    for (int a = 0; a < 18; a++) begin
      reg_rd(5'(a), rv);
      chk("reset value", rv, RST_TAB[a]);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    wait_clk(4);
    reset_n <= 1'b1;
    check_reset_vals();
    // Comparator control is left out: its status bits depend on the comparator inputs, polarity and filter
    for (int a = 0; a < 18; a++) begin
      if (a != 13 && a != 14) begin
        reg_wr(5'(a), 8'hFF);
      end
    end
    for (int a = 0; a < 18; a++) begin
      if (a != 13 && a != 14) begin
        reg_rd(5'(a), rv);
        chk("all ones", rv, ONES_TAB[a]);
      end
    end
    chk("cmp0 trim", {1'b0, ctl.cmp0_trim}, 8'h7F);
    chk("cmp1 trim", {1'b0, ctl.cmp1_trim}, 8'h7F);
    chk("hysteresis", {4'h0, ctl.cmp_hyst}, 8'h0F);
    reg_wr(5'h12, 8'hFF);
    reg_rd(5'h12, rv);
    chk("unmapped", rv, 8'h00);
    reg_wr(ADDR_SW_LOW, 8'hA5);
    reg_wr(ADDR_SW_HIGH, 8'h0A);
    chk("sw low", ctl.sw_closed[7:0], 8'hA5);
    chk("sw high", {3'b000, ctl.sw_closed[12:8]}, 8'h02);
    chk("cmp0 sel", {7'h00, ctl.cmp0_neg_input_sel}, 8'h01);
    chk("cmp1 sel", {7'h00, ctl.cmp1_neg_input_sel}, 8'h00);
    reg_wr(ADDR_SW_HIGH, 8'h15);
    chk("sw high", {3'b000, ctl.sw_closed[12:8]}, 8'h05);
    chk("cmp0 sel", {7'h00, ctl.cmp0_neg_input_sel}, 8'h00);
    chk("cmp1 sel", {7'h00, ctl.cmp1_neg_input_sel}, 8'h01);
    reg_wr(ADDR_DAC0_EN, 8'h80);
    reg_wr(ADDR_DAC1_EN, 8'h7F);
    reg_wr(ADDR_DAC2_EN, 8'h80);
    reg_wr(ADDR_DAC0_LVL, 8'h3C);
    reg_wr(ADDR_DAC1_LVL, 8'hC3);
    reg_wr(ADDR_DAC2_LVL, 8'h01);
    chk("dac on", {5'h00, ctl.ref_dac_on}, 8'h05);
    chk("dac0 code", ctl.dac0_code, 8'h3C);
    chk("dac1 code", ctl.dac1_code, 8'hC3);
    chk("dac2 code", ctl.dac2_code, 8'h01);
    for (int g = 0; g < 8; g++) begin
      reg_wr(ADDR_GAIN, {5'b10000, 3'(g)});
      chk("gain code", {5'h00, ctl.amp_gain_code}, 8'(g));
      chk("gain ratio", {2'b00, ctl.amp_gain_ratio}, RATIO_TAB[g]);
    end
    for (int i = 0; i < 2; i++) begin
      reg_wr(5'(ADDR_OPA0_CTL + i), 8'h41);
      chk("opamp on", {7'h00, ctl.opamp_on[i]}, 8'h01);
      reg_wr(5'(ADDR_OPA0_TRIM + i), 8'h15);
      opamp_out <= 2'b11;
      wait_clk(4);
      reg_rd(5'(ADDR_OPA0_CTL + i), rv);
      chk("opamp status off", rv, 8'h41);
      chk("trim code", {2'b00, (i == 0) ? ctl.opamp0_trim_code : ctl.opamp1_trim_code},
          8'h15);
      chk("cal ref", {7'h00, ctl.opamp_cal_ref_sel[i]}, 8'h00);
      reg_wr(5'(ADDR_OPA0_TRIM + i), 8'hC0);
      chk("cal mode", {7'h00, ctl.opamp_cal_mode[i]}, 8'h01);
      chk("cal ref", {7'h00, ctl.opamp_cal_ref_sel[i]}, 8'h01);
      wait_clk(4);
      reg_rd(5'(ADDR_OPA0_CTL + i), rv);
      chk("opamp status high", rv, 8'h61);
      opamp_out <= 2'b00;
      wait_clk(4);
      reg_rd(5'(ADDR_OPA0_CTL + i), rv);
      chk("opamp status low", rv, 8'h41);
    end
    for (int b = 0; b < 4; b++) begin
      reg_wr(ADDR_OPA0_CTL, 8'(b));
      reg_wr(ADDR_OPA1_CTL, 8'(3 - b));
      chk("bw0", {6'h00, ctl.opamp0_bandwidth_sel}, 8'(b));
      chk("bw1", {6'h00, ctl.opamp1_bandwidth_sel}, 8'(3 - b));
    end
    // Enable, inversion and raw level in every combination, no filtering
    for (int k = 0; k < 8; k++) begin
      reg_wr(ADDR_GAIN, {k[1], k[1], 6'h00});
      reg_wr(ADDR_CMP0_CTL, {1'b0, k[2], 6'h00});
      reg_wr(ADDR_CMP1_CTL, {1'b0, k[2], 6'h00});
      cmp_out <= {k[0], k[0]};
      wait_clk(6);
      reg_rd(ADDR_CMP0_CTL, rv);
      chk("cmp0 status", rv, {(k[0] & k[2]) ^ k[1], k[2], (k[0] & k[2]) ^ k[1], 5'h00});
      reg_rd(ADDR_CMP1_CTL, rv);
      chk("cmp1 status", rv, {(k[0] & k[2]) ^ k[1], k[2], (k[0] & k[2]) ^ k[1], 5'h00});
    end
    // Only comparator 0 inverted, so swapped polarity bits would show
    reg_wr(ADDR_GAIN, 8'h80);
    reg_wr(ADDR_CMP0_CTL, 8'hF3);
    reg_wr(ADDR_CMP1_CTL, 8'h42);
    wait_clk(4);
    reg_rd(ADDR_CMP0_CTL, rv);
    chk("cmp0 inverted", rv, 8'h43);
    reg_rd(ADDR_CMP1_CTL, rv);
    chk("cmp1 plain", rv, 8'hE2);
    chk("cmp on", {6'h00, ctl.cmp_on}, 8'h03);
    chk("cmp0 current", {6'h00, ctl.cmp0_current}, 8'h03);
    chk("cmp1 current", {6'h00, ctl.cmp1_current}, 8'h02);
    reg_wr(ADDR_GAIN, 8'h00);
    for (int f = 0; f < 4; f++) begin
      cmp_out <= 2'b00;
      reg_wr(ADDR_CMP0_CTL, {4'b0100, 2'(f), 2'b00});
      reg_wr(ADDR_CMP1_CTL, {4'b0100, 2'(f), 2'b00});
      wait_clk(150);
      @(posedge clk);
      cmp_out <= 2'b11;
      if (f != 0) begin
        wait_clk(DEB_LO[f]);
        reg_rd(ADDR_CMP0_CTL, rv);
        chk("cmp0 early", rv, {4'b1100, 2'(f), 2'b00});
        reg_rd(ADDR_CMP1_CTL, rv);
        chk("cmp1 early", rv, {4'b1100, 2'(f), 2'b00});
      end
      wait_clk(DEB_HI[f] - DEB_LO[f]);
      reg_rd(ADDR_CMP0_CTL, rv);
      chk("cmp0 late", rv, {4'b1110, 2'(f), 2'b00});
      reg_rd(ADDR_CMP1_CTL, rv);
      chk("cmp1 late", rv, {4'b1110, 2'(f), 2'b00});
    end
    // Second reset in mid-run must restore every register
    @(posedge clk);
    reset_n <= 1'b0;
    wait_clk(4);
    reset_n <= 1'b1;
    cmp_out <= 2'b00;
    check_reset_vals();
    close_out();
  end

  // Whole run needs well under 5000 cycles
  initial begin
    #400000;
    n_fail++;
    close_out();
  end
endmodule
